// ===== shared/ftbl_cfg.svh
// Purpose: offsets, reset values and structural defaults of the flux trip and bypass block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: configuration registers are 16 bits wide and sit in the low half of the word
`ifndef FTBL_CFG_SVH
`define FTBL_CFG_SVH

// ----------------------------------------
// structure
// ----------------------------------------
`define FTBL_N_DIV 4
`define FTBL_FLUX_W 16
`define FTBL_GAIN_FRAC 8
`define FTBL_SR_PER_GRP 2
`define FTBL_LF_PER_CH 4
`define FTBL_LF_PER_CELL 2
`define FTBL_STP_SHIFT 4
`define FTBL_PR_SW_W 3

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FTBL_REG_SR_HI_SP 6'h00
`define FTBL_REG_SR_PERM_SP 6'h04
`define FTBL_REG_PR_GAIN 6'h08
`define FTBL_REG_PR_HI_SP 6'h0C
`define FTBL_REG_PR_STP_SP 6'h10
`define FTBL_REG_PR_OSC_SP 6'h14
`define FTBL_REG_PR_PERM_SP 6'h18
`define FTBL_REG_SR_TRIP 6'h1C
`define FTBL_REG_SR_BYP 6'h20
`define FTBL_REG_PR_STAT 6'h24
`define FTBL_REG_DIV_STAT 6'h28

// ----------------------------------------
// reset values
// ----------------------------------------
`define FTBL_RST_SR_HI_SP 16'hC000
`define FTBL_RST_SR_PERM_SP 16'h1000
`define FTBL_RST_PR_GAIN 16'h0100
`define FTBL_RST_PR_HI_SP 16'hE000
`define FTBL_RST_PR_STP_SP 16'hD000
`define FTBL_RST_PR_OSC_SP 16'hE800
`define FTBL_RST_PR_PERM_SP 16'h2000

`endif

// ===== shared/ftbl_pkg.sv
// Purpose: shared types of the flux trip and bypass block
// Assumes: constants live in ftbl_cfg.svh
// Notes: bus states are Gray coded
package ftbl_pkg;
  typedef enum logic [1:0] {
    FTBL_BUS_IDLE = 2'b00,
    FTBL_BUS_ACK = 2'b01
  } ftbl_bus_t;
  typedef logic [15:0] ftbl_word_t;
endpackage

// ===== rtl/ftbl_pr_chan.sv
// Purpose: one power-range averaging channel with its oscillation cells
// Assumes: local flux words are already synchronised to clk
// Notes: all outputs are registered; hf_trip and perm lag the averaged power by one cycle
`include "ftbl_cfg.svh"

module ftbl_pr_chan #(
  parameter int LF_PER_CH = `FTBL_LF_PER_CH,
  parameter int LF_PER_CELL = `FTBL_LF_PER_CELL,
  parameter int STP_SHIFT = `FTBL_STP_SHIFT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [LF_PER_CH*`FTBL_FLUX_W-1:0] lf,
  input wire logic [`FTBL_FLUX_W-1:0] gain,
  input wire logic [`FTBL_FLUX_W-1:0] hi_sp,
  input wire logic [`FTBL_FLUX_W-1:0] stp_sp,
  input wire logic [`FTBL_FLUX_W-1:0] osc_sp,
  input wire logic [`FTBL_FLUX_W-1:0] perm_sp,
  output logic [`FTBL_FLUX_W-1:0] apower,
  output logic hf_trip,
  output logic stp_trip,
  output logic osc_trip,
  output logic perm
);
  localparam int FW = `FTBL_FLUX_W;
  localparam int FR = `FTBL_GAIN_FRAC;
  localparam int LG = $clog2(LF_PER_CH);
  localparam int LC = $clog2(LF_PER_CELL);

  typedef struct packed {
    logic [FW-1:0] apower;
    logic [FW-1:0] stp;
    logic hf;
    logic stpt;
    logic osc;
    logic perm;
  } ftbl_pr_st_t;

  ftbl_pr_st_t q;
  ftbl_pr_st_t n;

  // ----------------------------------------
  // averaging, normalisation and trips
  // ----------------------------------------
  always_comb begin
    logic [FW+LG-1:0] sum;
    logic [FW+LC-1:0] csum;
    logic [2*FW-1:0] prod;
    logic osc_any;
    sum = '0;
    csum = '0;
    prod = '0;
    osc_any = 1'b0;
    n = q;
    for (int i = 0; i < LF_PER_CH; i++) begin
      sum = sum + (FW+LG)'(lf[i*FW +: FW]);
    end
    // gain is fixed point; saturate rather than wrap so overrange stays tripped
    prod = (2*FW)'(sum[LG +: FW]) * (2*FW)'(gain);
    n.apower = (|prod[2*FW-1:FW+FR]) ? '1 : prod[FR +: FW];
    // first-order lag as simulated thermal power; residue below 2^shift never settles
    if (q.apower >= q.stp) begin
      n.stp = q.stp + ((q.apower - q.stp) >> STP_SHIFT);
    end else begin
      n.stp = q.stp - ((q.stp - q.apower) >> STP_SHIFT);
    end
    // one cell per input, each averaging a sliding run of neighbours
    for (int c = 0; c < LF_PER_CH; c++) begin
      csum = '0;
      for (int k = 0; k < LF_PER_CELL; k++) begin
        csum = csum + (FW+LC)'(lf[((c + k) % LF_PER_CH)*FW +: FW]);
      end
      if (csum[LC +: FW] > osc_sp) begin
        osc_any = 1'b1;
      end
    end
    n.osc = osc_any;
    n.hf = q.apower > hi_sp;
    n.stpt = q.stp > stp_sp;
    n.perm = q.apower > perm_sp;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign apower = q.apower;
  assign hf_trip = q.hf;
  assign stp_trip = q.stpt;
  assign osc_trip = q.osc;
  assign perm = q.perm;
endmodule

// ===== rtl/ftbl_top.sv
// Purpose: divisional trip, bypass and permissive logic of the flux monitoring system
// Assumes: pin inputs are asynchronous and pass two flip-flops; trip outputs are energise-to-run
// Notes: registers on Avalon-MM, every access answers with waitrequest low one cycle later
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`include "ftbl_cfg.svh"

module ftbl_top #(
  parameter int SR_PER_GRP = `FTBL_SR_PER_GRP,
  parameter int LF_PER_CH = `FTBL_LF_PER_CH,
  parameter int LF_PER_CELL = `FTBL_LF_PER_CELL,
  parameter int STP_SHIFT = `FTBL_STP_SHIFT,
  localparam int ND = `FTBL_N_DIV,
  localparam int NSR = ND * SR_PER_GRP,
  localparam int GW = $clog2(SR_PER_GRP + 1),
  localparam int FW = `FTBL_FLUX_W,
  localparam int PW = `FTBL_PR_SW_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NSR*FW-1:0] sr_flux,
  input wire logic [NSR-1:0] sr_short_period,
  input wire logic [NSR-1:0] sr_inop,
  input wire logic [ND*GW-1:0] sr_byp_sw,
  input wire logic [ND*LF_PER_CH*FW-1:0] lf_flux,
  input wire logic [ND-1:0] pr_inop,
  input wire logic [PW-1:0] pr_byp_sw,
  input wire logic [ND-1:0] div_pwr_ok,
  output logic [ND-1:0] sr_trip_n,
  output logic [ND-1:0] pr_trip_n,
  output logic [ND-1:0] sr_perm,
  output logic [ND-1:0] pr_perm,
  output logic [NSR-1:0] sr_byp_stat,
  output logic [ND-1:0] pr_byp_stat
);
  localparam int LFW = ND * LF_PER_CH * FW;
  localparam logic [GW-1:0] GMAX = GW'(SR_PER_GRP);
  localparam logic [PW-1:0] PMAX = PW'(ND);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (SR_PER_GRP < 1 || NSR > 32) begin : g_chk_sr
    $error("startup channels per group must give 1 to 32 channels");
  end
  if (LF_PER_CH < 2 || LF_PER_CH > 16 || (1 << $clog2(LF_PER_CH)) != LF_PER_CH) begin : g_chk_lf
    $error("local inputs per channel must be a power of two from 2 to 16");
  end
  if (LF_PER_CELL < 2 || LF_PER_CELL > LF_PER_CH
      || (1 << $clog2(LF_PER_CELL)) != LF_PER_CELL) begin : g_chk_cell
    $error("inputs per cell must be a power of two within the channel");
  end
  if (STP_SHIFT < 1 || STP_SHIFT > 15) begin : g_chk_stp
    $error("thermal filter shift must be 1 to 15");
  end

  typedef struct packed {
    ftbl_pkg::ftbl_bus_t bus;
    logic [31:0] rdata;
    ftbl_pkg::ftbl_word_t sr_hi_sp;
    ftbl_pkg::ftbl_word_t sr_perm_sp;
    ftbl_pkg::ftbl_word_t pr_gain;
    ftbl_pkg::ftbl_word_t pr_hi_sp;
    ftbl_pkg::ftbl_word_t pr_stp_sp;
    ftbl_pkg::ftbl_word_t pr_osc_sp;
    ftbl_pkg::ftbl_word_t pr_perm_sp;
    logic [NSR*FW-1:0] srf1;
    logic [NSR*FW-1:0] srf2;
    logic [NSR-1:0] srp1;
    logic [NSR-1:0] srp2;
    logic [NSR-1:0] sri1;
    logic [NSR-1:0] sri2;
    logic [ND*GW-1:0] sw1;
    logic [ND*GW-1:0] sw2;
    logic [LFW-1:0] lf1;
    logic [LFW-1:0] lf2;
    logic [ND-1:0] pi1;
    logic [ND-1:0] pi2;
    logic [ND-1:0] pw1;
    logic [ND-1:0] pw2;
    logic [PW-1:0] psw1;
    logic [PW-1:0] psw2;
    logic [ND*GW-1:0] sr_sel;
    logic [PW-1:0] pr_sel;
    logic [NSR-1:0] sr_trip;
    logic [NSR-1:0] sr_byp;
    logic [ND-1:0] pr_byp;
    logic [ND-1:0] sr_trip_n;
    logic [ND-1:0] pr_trip_n;
    logic [ND-1:0] sr_perm;
  } ftbl_state_t;

  localparam ftbl_state_t RST_ST = '{
    bus: ftbl_pkg::FTBL_BUS_IDLE,
    sr_hi_sp: `FTBL_RST_SR_HI_SP,
    sr_perm_sp: `FTBL_RST_SR_PERM_SP,
    pr_gain: `FTBL_RST_PR_GAIN,
    pr_hi_sp: `FTBL_RST_PR_HI_SP,
    pr_stp_sp: `FTBL_RST_PR_STP_SP,
    pr_osc_sp: `FTBL_RST_PR_OSC_SP,
    pr_perm_sp: `FTBL_RST_PR_PERM_SP,
    default: '0
  };

  ftbl_state_t q;
  ftbl_state_t n;
  logic [ND-1:0] ch_hf;
  logic [ND-1:0] ch_stp;
  logic [ND-1:0] ch_osc;
  logic [ND-1:0] ch_perm;

  // ----------------------------------------
  // power-range channels, one per division
  // ----------------------------------------
  for (genvar d = 0; d < ND; d++) begin : g_pr
    ftbl_pr_chan #(
      .LF_PER_CH(LF_PER_CH),
      .LF_PER_CELL(LF_PER_CELL),
      .STP_SHIFT(STP_SHIFT)
    ) u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .lf(q.lf2[d*LF_PER_CH*FW +: LF_PER_CH*FW]),
      .gain(q.pr_gain),
      .hi_sp(q.pr_hi_sp),
      .stp_sp(q.pr_stp_sp),
      .osc_sp(q.pr_osc_sp),
      .perm_sp(q.pr_perm_sp),
      .apower(),
      .hf_trip(ch_hf[d]),
      .stp_trip(ch_stp[d]),
      .osc_trip(ch_osc[d]),
      .perm(ch_perm[d])
    );
  end

  function automatic ftbl_pkg::ftbl_word_t ftbl_merge(
    input ftbl_pkg::ftbl_word_t old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    ftbl_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [GW-1:0] cur;
    logic [GW-1:0] sw;
    logic [ND-1:0] sr_div;
    logic [ND-1:0] perm_div;
    logic [ND-1:0] pr_div;
    logic [31:0] rd;
    cur = '0;
    sw = '0;
    sr_div = '0;
    perm_div = '0;
    pr_div = '0;
    rd = '0;
    n = q;
    // pins: first stage feeds only the second
    n.srf1 = sr_flux;
    n.srf2 = q.srf1;
    n.srp1 = sr_short_period;
    n.srp2 = q.srp1;
    n.sri1 = sr_inop;
    n.sri2 = q.sri1;
    n.sw1 = sr_byp_sw;
    n.sw2 = q.sw1;
    n.lf1 = lf_flux;
    n.lf2 = q.lf1;
    n.pi1 = pr_inop;
    n.pi2 = q.pi1;
    n.pw1 = div_pwr_ok;
    n.pw2 = q.pw1;
    n.psw1 = pr_byp_sw;
    n.psw2 = q.psw1;

    // startup bypass: one selector per group, code 0 is none, k+1 is slot k
    for (int g = 0; g < ND; g++) begin
      cur = q.sr_sel[g*GW +: GW];
      sw = q.sw2[g*GW +: GW];
      if (cur == '0) begin
        if (sw <= GMAX) begin
          n.sr_sel[g*GW +: GW] = sw;
        end
      end else if (sw == '0) begin
        n.sr_sel[g*GW +: GW] = '0;
      end
      // a move straight to another slot keeps the old one until the switch passes none
    end
    for (int i = 0; i < NSR; i++) begin
      n.sr_byp[i] = q.sr_sel[(i / SR_PER_GRP)*GW +: GW]
                    == GW'((i % SR_PER_GRP) + 1);
      n.sr_trip[i] = (q.srf2[i*FW +: FW] > q.sr_hi_sp) | q.srp2[i] | q.sri2[i];
      if (q.sr_trip[i] && !q.sr_byp[i]) begin
        sr_div[i % ND] = 1'b1;
      end
      if (q.srf2[i*FW +: FW] > q.sr_perm_sp && !q.sr_byp[i]) begin
        perm_div[i % ND] = 1'b1;
      end
    end

    // power bypass: a single system-wide selector, separate from the startup groups
    if (q.pr_sel == '0) begin
      if (q.psw2 <= PMAX) begin
        n.pr_sel = q.psw2;
      end
    end else if (q.psw2 == '0) begin
      n.pr_sel = '0;
    end
    for (int d = 0; d < ND; d++) begin
      n.pr_byp[d] = q.pr_sel == PW'(d + 1);
      // oscillation shares the channel's bypass, it has no switch of its own
      pr_div[d] = (ch_hf[d] | ch_stp[d] | ch_osc[d] | q.pi2[d])
                  & !q.pr_byp[d];
    end

    // de-energised output is the tripped state, so a dead division reads as tripped
    n.sr_trip_n = ~sr_div & q.pw2;
    n.pr_trip_n = ~pr_div & q.pw2;
    n.sr_perm = perm_div;

    unique case (avs_address)
      `FTBL_REG_SR_HI_SP: rd = {16'h0000, q.sr_hi_sp};
      `FTBL_REG_SR_PERM_SP: rd = {16'h0000, q.sr_perm_sp};
      `FTBL_REG_PR_GAIN: rd = {16'h0000, q.pr_gain};
      `FTBL_REG_PR_HI_SP: rd = {16'h0000, q.pr_hi_sp};
      `FTBL_REG_PR_STP_SP: rd = {16'h0000, q.pr_stp_sp};
      `FTBL_REG_PR_OSC_SP: rd = {16'h0000, q.pr_osc_sp};
      `FTBL_REG_PR_PERM_SP: rd = {16'h0000, q.pr_perm_sp};
      `FTBL_REG_SR_TRIP: rd = 32'(q.sr_trip);
      `FTBL_REG_SR_BYP: rd = 32'(q.sr_byp);
      `FTBL_REG_PR_STAT: rd = {12'h000, q.pr_byp, q.pi2, ch_osc, ch_stp, ch_hf};
      `FTBL_REG_DIV_STAT: rd = {12'h000, q.pw2, ch_perm, q.sr_perm, q.pr_trip_n, q.sr_trip_n};
      default: rd = 32'h0000_0000;
    endcase

    // bus: request seen in idle, answered one cycle later with waitrequest low
    unique case (q.bus)
      ftbl_pkg::FTBL_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          n.bus = ftbl_pkg::FTBL_BUS_ACK;
          n.rdata = rd;
        end
      end
      ftbl_pkg::FTBL_BUS_ACK: begin
        n.bus = ftbl_pkg::FTBL_BUS_IDLE;
        if (avs_write) begin
          unique case (avs_address)
            `FTBL_REG_SR_HI_SP: n.sr_hi_sp = ftbl_merge(q.sr_hi_sp, avs_writedata, avs_byteenable);
            `FTBL_REG_SR_PERM_SP:
              n.sr_perm_sp = ftbl_merge(q.sr_perm_sp, avs_writedata, avs_byteenable);
            `FTBL_REG_PR_GAIN: n.pr_gain = ftbl_merge(q.pr_gain, avs_writedata, avs_byteenable);
            `FTBL_REG_PR_HI_SP: n.pr_hi_sp = ftbl_merge(q.pr_hi_sp, avs_writedata, avs_byteenable);
            `FTBL_REG_PR_STP_SP:
              n.pr_stp_sp = ftbl_merge(q.pr_stp_sp, avs_writedata, avs_byteenable);
            `FTBL_REG_PR_OSC_SP:
              n.pr_osc_sp = ftbl_merge(q.pr_osc_sp, avs_writedata, avs_byteenable);
            `FTBL_REG_PR_PERM_SP:
              n.pr_perm_sp = ftbl_merge(q.pr_perm_sp, avs_writedata, avs_byteenable);
            default: n.bus = ftbl_pkg::FTBL_BUS_IDLE;
          endcase
        end
      end
      default: n.bus = ftbl_pkg::FTBL_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_ST;
    end else if (ce) begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.bus != ftbl_pkg::FTBL_BUS_ACK;
  assign sr_trip_n = q.sr_trip_n;
  assign pr_trip_n = q.pr_trip_n;
  assign sr_perm = q.sr_perm;
  assign pr_perm = ch_perm;
  assign sr_byp_stat = q.sr_byp;
  assign pr_byp_stat = q.pr_byp;
endmodule

// ===== verif/ftbl_checker.sv
// Purpose: port-level assertions of the flux trip and bypass block
// Assumes: ce held high; latencies follow the two-flop pin synchroniser
// Notes: bound into ftbl_top at the foot of this file
module ftbl_checker #(
  parameter int SR_PER_GRP = 2,
  localparam int NSR = 4 * SR_PER_GRP,
  localparam int GW = $clog2(SR_PER_GRP + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [NSR-1:0] sr_inop,
  input wire logic [4*GW-1:0] sr_byp_sw,
  input wire logic [2:0] pr_byp_sw,
  input wire logic [3:0] div_pwr_ok,
  input wire logic [3:0] sr_trip_n,
  input wire logic [3:0] pr_trip_n,
  input wire logic [NSR-1:0] sr_byp_stat,
  input wire logic [3:0] pr_byp_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic grp_over;
  // ----------------------------------------
  // helper and properties
  // ----------------------------------------
  always_comb begin
    grp_over = 1'b0;
    for (int g = 0; g < 4; g++) begin
      if ($countones(sr_byp_stat[g*SR_PER_GRP+:SR_PER_GRP]) > 1) begin
        grp_over = 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_SR_GRP_ONE: assert property (!grp_over)
    else $error("two startup channels bypassed in one group");
  AST_PR_BYP_ONE: assert property ($onehot0(pr_byp_stat))
    else $error("more than one power channel bypassed");
  // six samples cover sync, trip register and the slower bypass gating
  AST_SR_INOP_TRIP: assert property (
    (sr_inop[0] && sr_byp_sw[GW-1:0] == '0) [*6] |-> !sr_trip_n[0])
    else $error("inoperative startup channel did not trip");
  AST_PR_BYP_MASK: assert property (
    (pr_byp_stat[0] && div_pwr_ok[0]) [*6] |-> pr_trip_n[0])
    else $error("bypassed power channel still trips");
  AST_PR_BYP_SEL: assert property (
    pr_byp_sw == 3'h0 ##1 (pr_byp_sw == 3'h1) [*6] |-> pr_byp_stat == 4'h1)
    else $error("power bypass switch not followed");
  AST_SR_BYP_SEL: assert property (
    sr_byp_sw[1:0] == 2'h0 ##1 (sr_byp_sw[1:0] == 2'h2) [*6] |-> sr_byp_stat[1:0] == 2'h2)
    else $error("startup bypass switch not followed");
  AST_PR_REFUSE: assert property (
    pr_byp_sw == 3'h4 ##1 (pr_byp_sw == 3'h3) [*6] |-> pr_byp_stat != 4'h4)
    else $error("direct bypass change was taken");
  AST_PWR_LOSS: assert property (
    !div_pwr_ok[0] [*3] |-> ##[1:2] (!sr_trip_n[0] && !pr_trip_n[0]))
    else $error("unpowered division not tripped");
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  cover property (pr_byp_stat == 4'h1 && pr_trip_n[0]);
  cover property (!sr_trip_n[0] && sr_inop[0]);
  cover property (!avs_waitrequest && avs_write);
endmodule

bind ftbl_top ftbl_checker #(.SR_PER_GRP(SR_PER_GRP)) i_ftbl_checker (
  .clk(clk),
  .rst_n(rst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .sr_inop(sr_inop),
  .sr_byp_sw(sr_byp_sw),
  .pr_byp_sw(pr_byp_sw),
  .div_pwr_ok(div_pwr_ok),
  .sr_trip_n(sr_trip_n),
  .pr_trip_n(pr_trip_n),
  .sr_byp_stat(sr_byp_stat),
  .pr_byp_stat(pr_byp_stat)
);

// ===== verif/ftbl_voter.sv
// Purpose: far-side models of the divisional trip voter and the rod block check
// Assumes: active-low trips; either path trips its division
// Notes: two of four divisions trip; seal-in is left out
module ftbl_voter #(
  parameter logic [15:0] RB_SP = 16'hA000
) (
  input wire logic [3:0] sr_trip_n,
  input wire logic [3:0] pr_trip_n,
  input wire logic [63:0] lf_ch,
  input wire logic withdraw,
  output logic scram,
  output logic rod_block
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    int s;
    s = 0;
    scram = $countones(~(sr_trip_n & pr_trip_n)) >= 2;
    for (int j = 0; j < 4; j++) s += lf_ch[j*16+:16];
    // block threshold is an arbitrary stand-in; only its crossing matters here
    rod_block = withdraw && s / 4 > RB_SP;
  end
endmodule

// ===== verif/tb_top.sv
// Purpose: self-checking bench of the flux trip and bypass block
// Assumes: byte enables tied on; ce dropped once to prove the freeze; default parameters
// Notes: power checks wait out the thermal filter before comparing
`include "ftbl_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [127:0] sr_flux = '0;
  logic [7:0] sr_sp = '0;
  logic [7:0] sr_in = '0;
  logic [7:0] sr_sw = '0;
  logic [255:0] lf = '0;
  logic [3:0] pr_in = '0;
  logic [2:0] pr_sw = '0;
  logic [3:0] pok = 4'hF;
  logic [3:0] srt_n, prt_n, srp, prp, prb, et, ept, esp, epp, epb;
  logic [7:0] srb, eb;
  logic scram;
  logic rblk;
  logic withdraw = 1'b0;
  logic ce = 1'b1;
  logic [31:0] q;
  int fails = 0;
  int compares = 0;
  int rv[7] = '{32'hC000, 32'h1000, 32'h100, 32'hE000, 32'hD000, 32'hE800, 32'h2000};
  int sbyp[4] = '{default: 0};
  int pbyp = 0;
  logic [63:0] pat[4] = '{{4{16'hE002}}, {16'hF000, 16'hF000, 32'h0}, {4{16'hD800}},
    {4{16'h2002}}};
  always #2 clk = ~clk;
  ftbl_top i_ftbl_top (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .sr_flux(sr_flux),
    .sr_short_period(sr_sp), .sr_inop(sr_in), .sr_byp_sw(sr_sw), .lf_flux(lf),
    .pr_inop(pr_in), .pr_byp_sw(pr_sw), .div_pwr_ok(pok), .sr_trip_n(srt_n),
    .pr_trip_n(prt_n), .sr_perm(srp), .pr_perm(prp), .sr_byp_stat(srb), .pr_byp_stat(prb));
  ftbl_voter i_ftbl_voter (.sr_trip_n(srt_n), .pr_trip_n(prt_n), .lf_ch(lf[63:0]),
    .withdraw(withdraw), .scram(scram), .rod_block(rblk));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d, output logic [31:0] o);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report();
    end
    o = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // a nonzero code is only taken straight after the switch read zero
  task automatic srsw(int g, int c);
    if (c == 0) sbyp[g] = 0;
    else if (sr_sw[g*2+:2] == 2'h0 && c <= 2) sbyp[g] = c;
    sr_sw[g*2+:2] <= 2'(c);
  endtask
  task automatic psw(int c);
    if (c == 0) pbyp = 0;
    else if (pr_sw == 3'h0 && c <= 4) pbyp = c;
    pr_sw <= 3'(c);
  endtask
  task automatic check_all();
    int s;
    int ap;
    logic f;
    logic [15:0] x;
    et = pok;
    ept = pok;
    {esp, epp, epb, eb} = '0;
    for (int i = 0; i < 8; i++) begin
      x = sr_flux[i*16+:16];
      eb[i] = sbyp[i/2] == i % 2 + 1;
      if (!eb[i] && (x > rv[0] || sr_sp[i] || sr_in[i])) et[i%4] = 1'b0;
      if (!eb[i] && x > rv[1]) esp[i%4] = 1'b1;
    end
    for (int d = 0; d < 4; d++) begin
      s = 0;
      f = pr_in[d];
      for (int j = 0; j < 4; j++) begin
        s += lf[(d*4+j)*16+:16];
        if ((lf[(d*4+j)*16+:16] + lf[(d*4+(j+1)%4)*16+:16]) / 2 > rv[5]) f = 1'b1;
      end
      ap = s / 4 * rv[2] / 256;
      epp[d] = ap > rv[6];
      epb[d] = pbyp == d + 1;
      if ((f || ap > rv[3] || ap > rv[4]) && !epb[d]) ept[d] = 1'b0;
    end
    cmp("sr_trip_n", et, srt_n);
    cmp("pr_trip_n", ept, prt_n);
    cmp("sr_perm", esp, srp);
    cmp("pr_perm", epp, prp);
    cmp("sr_byp_stat", eb, srb);
    cmp("pr_byp_stat", epb, prb);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(12));
    tick(2);
    rst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      bus(1'b0, 6'(r * 4), 0, q);
      cmp("cfg", rv[r], q);
    end
    bus(1'b0, 6'h3C, 0, q);
    cmp("unmapped", 0, q);
    rv[1] = $urandom_range(16'h0800, 16'hBFFF);
    bus(1'b1, `FTBL_REG_SR_PERM_SP, {16'hFFFF, 16'(rv[1])}, q);
    bus(1'b1, `FTBL_REG_SR_BYP, 32'hFF, q);
    bus(1'b0, `FTBL_REG_SR_PERM_SP, 0, q);
    cmp("perm_sp", rv[1], q);
    bus(1'b0, `FTBL_REG_SR_BYP, 0, q);
    cmp("sr_byp_ro", 0, q);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) begin
        sr_flux[i*16+:16] <= k == 0 ? 16'hC001 : 16'hC000;
        sr_sp[i] <= k == 1;
        sr_in[i] <= k == 2;
        tick(8);
        check_all();
        sr_flux <= '0;
        sr_sp <= '0;
        sr_in <= '0;
        tick(1);
      end
    end
    for (int n = 0; n < 24; n++) begin
      for (int g = 0; g < 4; g++) srsw(g, 0);
      tick(4);
      for (int g = 0; g < 4; g++) srsw(g, $urandom_range(3));
      sr_flux <= {$urandom, $urandom, $urandom, $urandom};
      sr_sp <= 8'($urandom & $urandom & $urandom);
      tick(10);
      check_all();
    end
    sr_flux <= '0;
    sr_sp <= '0;
    srsw(0, 0);
    tick(4);
    srsw(0, 2);
    tick(8);
    srsw(0, 1);
    tick(8);
    check_all();
    for (int d = 0; d < 4; d++) begin
      for (int p = 0; p < 5; p++) begin
        if (p < 4) lf[d*64+:64] <= pat[p];
        else pr_in[d] <= 1'b1;
        withdraw <= p < 2;
        tick(300);
        check_all();
        cmp("rod_block", d == 0 && p == 0, rblk);
        lf <= '0;
        pr_in <= '0;
        tick(300);
      end
    end
    lf <= {4{pat[1]}};
    for (int k = 0; k < 2; k++) begin
      pr_in <= k ? 4'hF : 4'h0;
      for (int d = 0; d < 4; d++) begin
        psw(0);
        tick(4);
        psw(d + 1);
        tick(12);
        check_all();
      end
    end
    psw(3);
    tick(12);
    check_all();
    psw(0);
    lf <= '0;
    pr_in <= '0;
    tick(300);
    pok <= 4'hA;
    tick(8);
    check_all();
    cmp("scram", 1, scram);
    bus(1'b0, `FTBL_REG_DIV_STAT, 0, q);
    cmp("div_stat", {12'h0, pok, epp, esp, ept, et}, q);
    // with ce low a full-scale startup trip must not reach the outputs
    ce <= 1'b0;
    sr_flux <= '1;
    tick(8);
    cmp("frozen", et, srt_n);
    ce <= 1'b1;
    tick(8);
    check_all();
    final_report();
  end
endmodule
